// ---- tb_vat_top.sv ----
// self-checking bench for the anti-theft block
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin err_count++; \
   $display("CHECK FAILED %s exp %0h seen %0h", nm, e, s); end end
module tb_vat_top;
   logic        mclk_i, rst_i, cyc, we, ack, slow, arm_en, haz_p, horn_p, sel_skip;
   logic [3:0]  adr, btn, sel;
   logic [31:0] wdat, dout, wb_rd;
   logic        door, hood, tail, key_in, ignition_primary_feed, ignition_run_feed, fb, lock, unlock, haz, horn, sten;
   int          err_count, n_tests, cyc_cnt, seed, exp_state, exp_fl;
   int          haz_rises, lock_hi, unl_hi, horn_rises, rnd;
   vat_top #(.TICK_CYCLES(4), .LOCK_PULSE_TICKS(5), .PREARM_TICKS(6), .ARM_HALF_TICKS(4),
      .DIS_HALF_TICKS(2), .ALM_HALF_TICKS(2), .ALARM_ON_TICKS(20), .ALARM_OFF_TICKS(8),
      .ALARM_CYCLES(3)) vat_top_i (
      .mclk_i(mclk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dout), .wb_ack_o(ack),
      .rke_lock_i(btn[0]), .rke_unlock_i(btn[1]), .key_lock_i(btn[2]),
      .key_unlock_i(btn[3]), .door_open_i(door), .hood_open_i(hood),
      .tailgate_open_i(tail), .key_in_i(key_in), .ignition_primary_feed_i(ignition_primary_feed),
      .ignition_run_feed_i(ignition_run_feed), .lock_fb_i(fb), .lock_o(lock), .unlock_o(unlock),
      .hazard_o(haz), .horn_o(horn), .start_en_o(sten));
   vat_body_model vat_body_model_i (.mclk_i(mclk_i), .rst_i(rst_i), .slow_i(slow),
      .lock_drv_i(lock), .unlock_drv_i(unlock), .locked_o(fb));
   initial begin
      mclk_i = 1'b0;
      forever #5 mclk_i = ~mclk_i;
   end
   always @(posedge mclk_i) begin
      cyc_cnt++;
      if (cyc_cnt > 10000) begin
         err_count++;
         report_and_stop();
      end
      lock_hi += lock;
      unl_hi += unlock;
      if (haz === 1'b1 && haz_p === 1'b0) haz_rises++;
      if (horn === 1'b1 && horn_p === 1'b0) horn_rises++;
      haz_p = haz;
      horn_p = horn;
   end
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : report_and_stop
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      rnd = $random(seed);
      sel <= {rnd[3:1], !sel_skip};
      do begin
         @(posedge mclk_i);
         n++;
      end while (ack !== 1'b1 && n < 50);
      wb_rd = dout;
      if (n >= 50) err_count++;
      cyc <= 1'b0;
      @(posedge mclk_i);
   endtask : wb
   task automatic clr();
      haz_rises = 0;
      lock_hi = 0;
      unl_hi = 0;
      horn_rises = 0;
   endtask : clr
   // reference: 0 remote lock, 1 remote unlock, 2/3 key lock/unlock
   function automatic void model(input int b);
      exp_fl = 0;
      if (b == 1) begin
         exp_state = vat_pkg::VAT_DISARMED;
         exp_fl = 2;
      end else if (b == 0 && arm_en) begin
         if (exp_state == vat_pkg::VAT_ARMED) exp_fl = 1;
         else if (door || hood || tail) exp_state = vat_pkg::VAT_PREARM;
         else begin
            exp_state = vat_pkg::VAT_ARMED;
            exp_fl = 1;
         end
      end
   endfunction : model
   task automatic chk_state();
      wb(1'b0, 4'h4, 32'h0);
      `CHK("state", exp_state[2:0], wb_rd[2:0])
   endtask : chk_state
   task automatic ev(input int b, input int w);
      clr();
      btn <= 4'h1 << b;
      repeat (4) @(posedge mclk_i);
      model(b);
      btn <= 4'h0;
      repeat (w) @(posedge mclk_i);
      chk_state();
      `CHK("flashes", exp_fl, haz_rises)
      if (b == 0) `CHK("lock pulse", 1'b1, lock_hi inside {[20:24]})
      if (b == 1) `CHK("unlock pulse", 1'b1, unl_hi inside {[20:24]})
   endtask : ev
   initial begin
      seed = 32'h485c;
      {cyc, we, adr, wdat, btn, slow, door, hood, tail, key_in, ignition_primary_feed, ignition_run_feed, sel_skip} = '0;
      arm_en = 1'b1;
      exp_state = vat_pkg::VAT_DISARMED;
      rst_i = 1'b1;
      repeat (12) @(posedge mclk_i);
      rst_i <= 1'b0;
      @(posedge mclk_i);
      `CHK("start", 1'b1, sten)
      sel_skip = 1'b1;
      wb(1'b1, 4'h0, 32'h0);
      sel_skip = 1'b0;
      wb(1'b0, 4'h0, 32'h0);
      `CHK("ctrl", 32'h1, wb_rd)
      wb(1'b0, 4'h8, 32'h0);
      `CHK("unmapped", 32'h0, wb_rd)
      arm_en = 1'b0;
      wb(1'b1, 4'h0, 32'h0);
      ev(0, 150);
      arm_en = 1'b1;
      wb(1'b1, 4'h0, 32'h1);
      ev(1, 100);
      rnd = $random(seed);
      {tail, hood, door} <= 3'h1 << (rnd[1:0] % 3);
      ev(0, 60);
      hood <= 1'b1;
      repeat (40) @(posedge mclk_i);
      `CHK("quiet", 3'h0, {horn, haz, horn_rises[0]})
      {door, hood, tail} <= 3'h0;
      clr();
      repeat (150) @(posedge mclk_i);
      exp_state = vat_pkg::VAT_ARMED;
      chk_state();
      `CHK("arm flash", 1, haz_rises)
      ev(0, 150);
      ev(3, 60);
      ev(2, 60);
      tail <= 1'b1;
      clr();
      repeat (6) @(posedge mclk_i);
      `CHK("alarm", 2'b10, {horn, sten})
      tail <= 1'b0;
      repeat (420) @(posedge mclk_i);
      `CHK("cycles", 3, horn_rises)
      `CHK("inhibit", 2'b00, {horn, sten})
      exp_state = vat_pkg::VAT_INHIBIT;
      chk_state();
      ev(0, 150);
      ev(1, 100);
      `CHK("start", 1'b1, sten)
      ev(2, 60);
      for (int i = 0; i < 4; i++) begin
         rnd = $random(seed);
         slow <= rnd[0];
         ev(0, 200);
         rnd = $random(seed);
         {key_in, ignition_primary_feed, ignition_run_feed} <= rnd[2:0] | {3{i == 3}};
         clr();
         repeat (20) @(posedge mclk_i);
         if (key_in && ignition_primary_feed && ignition_run_feed) exp_state = vat_pkg::VAT_DISARMED;
         chk_state();
         `CHK("no flash", 0, haz_rises)
         {key_in, ignition_primary_feed, ignition_run_feed} <= 3'b000;
         ev(1, 100);
      end
      report_and_stop();
   end
endmodule : tb_vat_top

// ---- vat_body_model.sv ----
// lock actuator model: reports the last commanded position, promptly or late
`timescale 1ns/1ps
module vat_body_model (
   input  wire logic mclk_i,       // system clock
   input  wire logic rst_i,        // async reset
   input  wire logic slow_i,       // high: actuator answers late
   input  wire logic lock_drv_i,   // lock drive from the block
   input  wire logic unlock_drv_i, // unlock drive from the block
   output logic      locked_o      // actuators report locked
);
   logic [7:0] dly_q;
   logic       tgt_q;
   // feedback moves only after the drive pulse ends and the travel time runs out
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         dly_q    <= 8'h00;
         tgt_q    <= 1'b0;
         locked_o <= 1'b0;
      end else if (lock_drv_i || unlock_drv_i) begin
         tgt_q <= lock_drv_i;
         dly_q <= slow_i ? 8'h40 : 8'h02;
      end else if (dly_q != 8'h00) begin
         dly_q <= dly_q - 8'h01;
      end else begin
         locked_o <= tgt_q;
      end
   end
endmodule : vat_body_model

// ---- vat_flash_if.sv ----
// control path between the state machine and the hazard flasher
`timescale 1ns/1ps
interface vat_flash_if;
   logic              tick;
   logic              start;
   logic              stop;
   logic              cont;
   logic [1:0]        count;
   vat_pkg::vat_ticks_t half_ticks;
   logic              lamp;
   modport ctl (output tick, output start, output stop, output cont, output count,
                output half_ticks, input lamp);
   modport gen (input tick, input start, input stop, input cont, input count,
                input half_ticks, output lamp);
endinterface : vat_flash_if

// ---- vat_flasher.sv ----
// hazard lamp pattern generator: counted or continuous square flashes
`timescale 1ns/1ps
module vat_flasher (
   input  wire logic mclk_i,  // system clock
   input  wire logic rst_i,   // async reset, active high
   vat_flash_if.gen  f        // pattern requests and lamp level
);
   logic                active_q;
   logic                pend_q;
   logic                lamp_q;
   logic                cont_q;
   logic [1:0]          left_q;
   vat_pkg::vat_ticks_t half_q;
   vat_pkg::vat_ticks_t ph_q;

   assign f.lamp = lamp_q;

   // start wins over stop so a new pattern can replace a running one
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         active_q <= 1'b0;
         pend_q   <= 1'b0;
         lamp_q   <= 1'b0;
         cont_q   <= 1'b0;
         left_q   <= 2'h0;
         half_q   <= 16'h0001;
         ph_q     <= 16'h0000;
      end else if (f.start) begin
         active_q <= 1'b1;
         pend_q   <= 1'b1;
         lamp_q   <= 1'b0;
         cont_q   <= f.cont;
         left_q   <= f.count;
         half_q   <= f.half_ticks;
         ph_q     <= 16'h0000;
      end else if (f.stop) begin
         active_q <= 1'b0;
         lamp_q   <= 1'b0;
      end else if (active_q && f.tick) begin
         if (pend_q) begin // lamp waits for a tick so every half is whole
            pend_q <= 1'b0;
            lamp_q <= 1'b1;
         end else if (ph_q == half_q - 16'h0001) begin
            ph_q <= 16'h0000;
            if (lamp_q) begin
               lamp_q <= 1'b0;
            end else if (!cont_q && left_q <= 2'h1) begin
               active_q <= 1'b0;
            end else begin
               lamp_q <= 1'b1;
               left_q <= left_q - 2'h1;
            end
         end else begin
            ph_q <= ph_q + 16'h0001;
         end
      end
   end
endmodule : vat_flasher

// ---- vat_pkg.sv ----
// types shared by the anti-theft block
package vat_pkg;
   typedef enum logic [2:0] {
      VAT_DISARMED = 3'h0,
      VAT_PREARM   = 3'h1,
      VAT_ARMED    = 3'h2,
      VAT_ALARM    = 3'h3,
      VAT_INHIBIT  = 3'h4
   } vat_state_e;
   typedef logic [15:0] vat_ticks_t;
endpackage : vat_pkg

// ---- vat_regs.svh ----
// register offsets, field positions, reset values and timing figures of the anti-theft block
`ifndef VAT_REGS_SVH
`define VAT_REGS_SVH

`define VAT_CLK_PERIOD_NS          10
`define VAT_TICK_NS                1000000
`define VAT_TICK_CYCLES            (`VAT_TICK_NS / `VAT_CLK_PERIOD_NS)
`define VAT_TICK_MS                1

`define VAT_LOCK_PULSE_MS          500
`define VAT_PREARM_MS              600
`define VAT_ARM_FLASH_PERIOD_MS    2000
`define VAT_DISARM_FLASH_PERIOD_MS 1000
`define VAT_ALARM_FLASH_PERIOD_MS  1000
`define VAT_ALARM_ON_MS            27000
`define VAT_ALARM_OFF_MS           10000
`define VAT_ALARM_CYCLES           3
`define VAT_ARM_FLASHES            2'h1
`define VAT_DISARM_FLASHES         2'h2

`define VAT_REG_CTRL               4'h0
`define VAT_REG_STATUS             4'h4
`define VAT_CTRL_ARM_EN_BIT        0
`define VAT_CTRL_RESET             1'h1
`define VAT_STAT_STATE_LSB         0
`define VAT_STAT_CYCLE_LSB         4
`define VAT_STAT_ALARM_ON_BIT      8
`define VAT_STAT_START_EN_BIT      9
`define VAT_STAT_HAZARD_BIT        10
`define VAT_STAT_HORN_BIT          11
`define VAT_STAT_OPEN_BIT          16
`define VAT_STAT_KEY_IN_BIT        17
`define VAT_STAT_IGN_BIT           18
`define VAT_STAT_LOCKED_BIT        20

`endif

// ---- vat_top.sv ----
// anti-theft state machine with lock pulses, hazard, horn and starter drive
//
// Notes on behaviour
// - remote lock gives one half-second lock pulse
// - remote unlock gives one half-second unlock pulse
// - arming passes pre-armed; triggers ignored there
// - remote lock enters pre-armed from alarm/inhibit/disarmed
// - pre-armed keeps horn and hazard warnings off; disarm flashes still running on entry from disarmed are not stopped
// - arm after 0.6 s if locked, closed, keyless
// - entering armed flashes hazard once, 2 s
// - lock with opening open: pulse, no flash
// - lock while armed flashes hazard once again
// - mechanical key lock never arms
// - remote unlock disarms; two 1 s flashes
// - armed, key in, both feeds on: disarm
// - disarmed: warnings off, starter enabled
// - unlock while disarmed flashes twice again
// - mechanical key unlock never disarms
// - armed and opening opened: alarm, starter off
// - alarm: three cycles, 27 s on, 10 s off
// - alarm on period flashes hazard at 1 s
// - door opened by key is still intrusion
// - after three cycles: start-inhibit, silent, no start
//
// Chosen here: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "vat_regs.svh"
module vat_top #(
   parameter int unsigned TICK_CYCLES      = `VAT_TICK_CYCLES,
   parameter int unsigned LOCK_PULSE_TICKS = `VAT_LOCK_PULSE_MS / `VAT_TICK_MS,
   parameter int unsigned PREARM_TICKS     = `VAT_PREARM_MS / `VAT_TICK_MS,
   parameter int unsigned ARM_HALF_TICKS   = `VAT_ARM_FLASH_PERIOD_MS / 2 / `VAT_TICK_MS,
   parameter int unsigned DIS_HALF_TICKS   = `VAT_DISARM_FLASH_PERIOD_MS / 2 / `VAT_TICK_MS,
   parameter int unsigned ALM_HALF_TICKS   = `VAT_ALARM_FLASH_PERIOD_MS / 2 / `VAT_TICK_MS,
   parameter int unsigned ALARM_ON_TICKS   = `VAT_ALARM_ON_MS / `VAT_TICK_MS,
   parameter int unsigned ALARM_OFF_TICKS  = `VAT_ALARM_OFF_MS / `VAT_TICK_MS,
   parameter int unsigned ALARM_CYCLES     = `VAT_ALARM_CYCLES
) (
   input  wire logic        mclk_i,                  // system clock, 100 MHz
   input  wire logic        rst_i,                   // async reset, active high
   input  wire logic        wb_cyc_i,                // wishbone cycle
   input  wire logic        wb_stb_i,                // wishbone strobe
   input  wire logic        wb_we_i,                 // wishbone write enable
   input  wire logic [3:0]  wb_adr_i,                // wishbone byte address
   input  wire logic [3:0]  wb_sel_i,                // wishbone byte selects
   input  wire logic [31:0] wb_dat_i,                // wishbone write data
   output logic      [31:0] wb_dat_o,                // wishbone read data
   output logic             wb_ack_o,                // wishbone acknowledge
   input  wire logic        rke_lock_i,              // remote lock button, high while pressed
   input  wire logic        rke_unlock_i,            // remote unlock button, high while pressed
   input  wire logic        key_lock_i,              // mechanical key lock switch
   input  wire logic        key_unlock_i,            // mechanical key unlock switch
   input  wire logic        door_open_i,             // any door open
   input  wire logic        hood_open_i,             // hood open
   input  wire logic        tailgate_open_i,         // tailgate open
   input  wire logic        key_in_i,                // key in ignition
   input  wire logic        ignition_primary_feed_i, // first ignition feed on
   input  wire logic        ignition_run_feed_i,     // run ignition feed on
   input  wire logic        lock_fb_i,               // lock actuators report locked
   output logic             lock_o,                  // door lock drive
   output logic             unlock_o,                // door unlock drive
   output logic             hazard_o,                // hazard lamp relay
   output logic             horn_o,                  // horn relay
   output logic             start_en_o               // starter enable
);
   localparam int NSYNC = 11;

   vat_flash_if f ();

   logic [NSYNC-1:0]    s1_q;
   logic [NSYNC-1:0]    s2_q;
   logic [NSYNC-1:0]    prev_q;
   logic                lock_ev;
   logic                unlock_ev;
   logic                klock_ev;
   logic                kunlock_ev;
   logic                opening;
   logic                key_in;
   logic                ign_both;
   logic                secure;
   logic [16:0]         tdiv_q;
   logic                tick_q;
   vat_pkg::vat_state_e st_q;
   vat_pkg::vat_state_e st_d;
   vat_pkg::vat_ticks_t tmr_q;
   vat_pkg::vat_ticks_t tmr_d;
   logic [1:0]          cyc_q;
   logic [1:0]          cyc_d;
   logic                on_q;
   logic                on_d;
   vat_pkg::vat_ticks_t act_q;
   logic                lock_q;
   logic                unlock_q;
   logic                hazard_q;
   logic                horn_q;
   logic                start_en_q;
   logic                arm_en_q;
   logic                ack_q;
   logic [31:0]         dat_q;
   logic                bus_req;

   // pins are asynchronous to mclk; first stage feeds only the second
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         s1_q <= '0;
         s2_q <= '0;
      end else begin
         s1_q <= {lock_fb_i, ignition_run_feed_i, ignition_primary_feed_i, key_in_i,
                  tailgate_open_i, hood_open_i, door_open_i,
                  key_unlock_i, key_lock_i, rke_unlock_i, rke_lock_i};
         s2_q <= s1_q;
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         prev_q <= '0;
      end else begin
         prev_q <= s2_q;
      end
   end

   assign lock_ev    = s2_q[0] & ~prev_q[0];
   assign unlock_ev  = s2_q[1] & ~prev_q[1];
   assign klock_ev   = s2_q[2] & ~prev_q[2];
   assign kunlock_ev = s2_q[3] & ~prev_q[3];
   assign opening    = s2_q[4] | s2_q[5] | s2_q[6];
   assign key_in     = s2_q[7];
   assign ign_both   = s2_q[8] & s2_q[9];
   assign secure     = s2_q[10] & ~opening & ~key_in;

   // one millisecond tick shared by every timer
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         tdiv_q <= 17'h00000;
         tick_q <= 1'b0;
      end else if (tdiv_q == 17'(TICK_CYCLES - 1)) begin
         tdiv_q <= 17'h00000;
         tick_q <= 1'b1;
      end else begin
         tdiv_q <= tdiv_q + 17'h00001;
         tick_q <= 1'b0;
      end
   end

   assign f.tick = tick_q;

   function automatic logic expired(input vat_pkg::vat_ticks_t t, input int unsigned n);
      expired = tick_q && (t >= 16'(n - 1));
   endfunction : expired

   // state machine; key switches are not read here so they never arm or disarm
   always_comb begin
      st_d         = st_q;
      tmr_d        = (tick_q && tmr_q != 16'hffff) ? tmr_q + 16'h0001 : tmr_q;
      cyc_d        = cyc_q;
      on_d         = on_q;
      f.start      = 1'b0;
      f.stop       = 1'b0;
      f.cont       = 1'b0;
      f.count      = `VAT_ARM_FLASHES;
      f.half_ticks = 16'(ARM_HALF_TICKS);
      unique case (st_q)
         vat_pkg::VAT_DISARMED: begin
            if (lock_ev && arm_en_q) begin
               st_d  = vat_pkg::VAT_PREARM;
               tmr_d = 16'h0000;
            end else if (unlock_ev) begin
               f.start      = 1'b1;
               f.count      = `VAT_DISARM_FLASHES;
               f.half_ticks = 16'(DIS_HALF_TICKS);
            end
         end
         vat_pkg::VAT_PREARM: begin
            // triggers are not looked at here; an open entrance only delays arming
            if (unlock_ev) begin
               st_d         = vat_pkg::VAT_DISARMED;
               f.start      = 1'b1;
               f.count      = `VAT_DISARM_FLASHES;
               f.half_ticks = 16'(DIS_HALF_TICKS);
            end else if (expired(tmr_q, PREARM_TICKS) && secure) begin
               st_d    = vat_pkg::VAT_ARMED;
               f.start = 1'b1;
            end
         end
         vat_pkg::VAT_ARMED: begin
            if (unlock_ev) begin
               st_d         = vat_pkg::VAT_DISARMED;
               f.start      = 1'b1;
               f.count      = `VAT_DISARM_FLASHES;
               f.half_ticks = 16'(DIS_HALF_TICKS);
            end else if (key_in && ign_both) begin
               st_d   = vat_pkg::VAT_DISARMED;
               f.stop = 1'b1;
            end else if (opening) begin
               st_d         = vat_pkg::VAT_ALARM;
               tmr_d        = 16'h0000;
               cyc_d        = 2'h0;
               on_d         = 1'b1;
               f.start      = 1'b1;
               f.cont       = 1'b1;
               f.half_ticks = 16'(ALM_HALF_TICKS);
            end else if (lock_ev) begin
               f.start = 1'b1;
            end
         end
         vat_pkg::VAT_ALARM: begin
            if (unlock_ev) begin
               st_d         = vat_pkg::VAT_DISARMED;
               f.start      = 1'b1;
               f.count      = `VAT_DISARM_FLASHES;
               f.half_ticks = 16'(DIS_HALF_TICKS);
            end else if (lock_ev && arm_en_q) begin
               st_d   = vat_pkg::VAT_PREARM;
               tmr_d  = 16'h0000;
               f.stop = 1'b1;
            end else if (on_q && expired(tmr_q, ALARM_ON_TICKS)) begin
               on_d   = 1'b0;
               tmr_d  = 16'h0000;
               f.stop = 1'b1;
            end else if (!on_q && expired(tmr_q, ALARM_OFF_TICKS)) begin
               tmr_d = 16'h0000;
               if (cyc_q == 2'(ALARM_CYCLES - 1)) begin
                  st_d = vat_pkg::VAT_INHIBIT;
               end else begin
                  cyc_d        = cyc_q + 2'h1;
                  on_d         = 1'b1;
                  f.start      = 1'b1;
                  f.cont       = 1'b1;
                  f.half_ticks = 16'(ALM_HALF_TICKS);
               end
            end
         end
         vat_pkg::VAT_INHIBIT: begin
            if (unlock_ev) begin
               st_d         = vat_pkg::VAT_DISARMED;
               f.start      = 1'b1;
               f.count      = `VAT_DISARM_FLASHES;
               f.half_ticks = 16'(DIS_HALF_TICKS);
            end else if (lock_ev && arm_en_q) begin
               st_d  = vat_pkg::VAT_PREARM;
               tmr_d = 16'h0000;
            end
         end
         default: begin
            st_d   = vat_pkg::VAT_DISARMED;
            f.stop = 1'b1;
         end
      endcase
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         st_q  <= vat_pkg::VAT_DISARMED;
         tmr_q <= 16'h0000;
         cyc_q <= 2'h0;
         on_q  <= 1'b0;
      end else begin
         st_q  <= st_d;
         tmr_q <= tmr_d;
         cyc_q <= cyc_d;
         on_q  <= on_d;
      end
   end

   vat_flasher u_flasher (
      .mclk_i (mclk_i),
      .rst_i  (rst_i),
      .f      (f.gen)
   );

   // lock actuator pulses; a newer command restarts the pulse in its own direction
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         act_q    <= 16'h0000;
         lock_q   <= 1'b0;
         unlock_q <= 1'b0;
      end else if (lock_ev || klock_ev) begin
         act_q    <= 16'h0000;
         lock_q   <= 1'b1;
         unlock_q <= 1'b0;
      end else if (unlock_ev || kunlock_ev) begin
         act_q    <= 16'h0000;
         lock_q   <= 1'b0;
         unlock_q <= 1'b1;
      end else if ((lock_q || unlock_q) && tick_q) begin
         if (act_q == 16'(LOCK_PULSE_TICKS)) begin
            lock_q   <= 1'b0;
            unlock_q <= 1'b0;
         end else begin
            act_q <= act_q + 16'h0001;
         end
      end
   end

   // warning and starter outputs; horn only in the on phase of an alarm
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         hazard_q   <= 1'b0;
         horn_q     <= 1'b0;
         start_en_q <= 1'b1;
      end else begin
         hazard_q   <= f.lamp;
         horn_q     <= (st_q == vat_pkg::VAT_ALARM) && on_q;
         start_en_q <= (st_q != vat_pkg::VAT_ALARM) && (st_q != vat_pkg::VAT_INHIBIT);
      end
   end

   assign lock_o     = lock_q;
   assign unlock_o   = unlock_q;
   assign hazard_o   = hazard_q;
   assign horn_o     = horn_q;
   assign start_en_o = start_en_q;

   // wishbone slave: one wait state, unmapped reads return zero
   function automatic logic [31:0] rd_word(input logic [3:0] adr);
      rd_word = 32'h0000_0000;
      if (adr == `VAT_REG_CTRL) begin
         rd_word[`VAT_CTRL_ARM_EN_BIT] = arm_en_q;
      end else if (adr == `VAT_REG_STATUS) begin
         rd_word[`VAT_STAT_STATE_LSB +: 3] = st_q;
         rd_word[`VAT_STAT_CYCLE_LSB +: 2] = cyc_q;
         rd_word[`VAT_STAT_ALARM_ON_BIT]   = on_q;
         rd_word[`VAT_STAT_START_EN_BIT]   = start_en_q;
         rd_word[`VAT_STAT_HAZARD_BIT]     = hazard_q;
         rd_word[`VAT_STAT_HORN_BIT]       = horn_q;
         rd_word[`VAT_STAT_OPEN_BIT]       = opening;
         rd_word[`VAT_STAT_KEY_IN_BIT]     = key_in;
         rd_word[`VAT_STAT_IGN_BIT +: 2]   = s2_q[9:8];
         rd_word[`VAT_STAT_LOCKED_BIT]     = s2_q[10];
      end
   endfunction : rd_word

   assign bus_req = wb_cyc_i && wb_stb_i && !ack_q;

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         dat_q <= 32'h0000_0000;
      end else begin
         ack_q <= bus_req;
         dat_q <= (bus_req && !wb_we_i) ? rd_word(wb_adr_i) : 32'h0000_0000;
      end
   end

   // arming enable; when cleared, remote lock only drives the locks, except in armed where it still flashes once
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         arm_en_q <= `VAT_CTRL_RESET;
      end else if (bus_req && wb_we_i && wb_sel_i[0] && wb_adr_i == `VAT_REG_CTRL) begin
         arm_en_q <= wb_dat_i[`VAT_CTRL_ARM_EN_BIT];
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;
endmodule : vat_top

// ---- vat_top_monitor.sv ----
// port assertions for the anti-theft block
`timescale 1ns/1ps
module vat_top_monitor #(
   parameter int unsigned TICK_CYCLES      = 100000,
   parameter int unsigned LOCK_PULSE_TICKS = 500,
   parameter int unsigned ARM_HALF_TICKS   = 1000,
   parameter int unsigned DIS_HALF_TICKS   = 500,
   parameter int unsigned ALM_HALF_TICKS   = 500,
   parameter int unsigned ALARM_ON_TICKS   = 27000
) (
   input wire logic mclk_i,     // system clock
   input wire logic rst_i,      // async reset
   input wire logic lock_o,     // lock drive
   input wire logic unlock_o,   // unlock drive
   input wire logic hazard_o,   // hazard relay
   input wire logic horn_o,     // horn relay
   input wire logic start_en_o  // starter enable
);
   localparam int unsigned T  = TICK_CYCLES;
   localparam int unsigned LP = LOCK_PULSE_TICKS * T;
   localparam int unsigned ON = ALARM_ON_TICKS * T;
   int unsigned lock_len_q, unl_len_q, horn_len_q, haz_len_q;
   // run lengths of the high level of lock, unlock, horn and hazard, read at the falling edge
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         lock_len_q <= 0;
         unl_len_q  <= 0;
         horn_len_q <= 0;
         haz_len_q  <= 0;
      end else begin
         lock_len_q <= lock_o ? lock_len_q + 1 : 0;
         unl_len_q  <= unlock_o ? unl_len_q + 1 : 0;
         horn_len_q <= horn_o ? horn_len_q + 1 : 0;
         haz_len_q  <= hazard_o ? haz_len_q + 1 : 0;
      end
   end
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   sequence s_alarm_entry;
      $fell(start_en_o);
   endsequence
   property p_lock_len;
      $fell(lock_o) |-> lock_len_q >= LP && lock_len_q <= LP + T;
   endproperty
   property p_unl_len;
      $fell(unlock_o) |-> unl_len_q >= LP && unl_len_q <= LP + T;
   endproperty
   property p_excl;
      !(lock_o && unlock_o);
   endproperty
   property p_reset_out;
      $fell(rst_i) |-> start_en_o && !horn_o && !hazard_o && !lock_o && !unlock_o;
   endproperty
   property p_horn_nostart;
      horn_o |-> !start_en_o;
   endproperty
   property p_start_fall;
      s_alarm_entry |-> ##[0:2] horn_o;
   endproperty
   property p_horn_len;
      $fell(horn_o) |-> horn_len_q + T >= ON && horn_len_q <= ON + T;
   endproperty
   property p_alm_flash;
      $fell(hazard_o) && horn_o |-> haz_len_q == ALM_HALF_TICKS * T;
   endproperty
   property p_flash_half;
      $fell(hazard_o) && !horn_o |-> haz_len_q == ARM_HALF_TICKS * T ||
         haz_len_q == DIS_HALF_TICKS * T || haz_len_q == ALM_HALF_TICKS * T;
   endproperty
   a_lock_len: assert property (p_lock_len) else $error("lock pulse length off");
   a_unl_len: assert property (p_unl_len) else $error("unlock pulse length off");
   a_excl: assert property (p_excl) else $error("lock and unlock together");
   a_reset_out: assert property (p_reset_out) else $error("outputs wrong after reset");
   a_horn_nostart: assert property (p_horn_nostart) else $error("horn with start on");
   a_start_fall: assert property (p_start_fall) else $error("start off without horn");
   a_horn_len: assert property (p_horn_len) else $error("horn on period length off");
   a_alm_flash: assert property (p_alm_flash) else $error("alarm flash half off");
   a_flash_half: assert property (p_flash_half) else $error("flash half length off");
endmodule : vat_top_monitor
bind vat_top vat_top_monitor #(
   .TICK_CYCLES(TICK_CYCLES), .LOCK_PULSE_TICKS(LOCK_PULSE_TICKS),
   .ARM_HALF_TICKS(ARM_HALF_TICKS), .DIS_HALF_TICKS(DIS_HALF_TICKS),
   .ALM_HALF_TICKS(ALM_HALF_TICKS), .ALARM_ON_TICKS(ALARM_ON_TICKS)
) vat_top_monitor_i (
   .mclk_i(mclk_i), .rst_i(rst_i), .lock_o(lock_o), .unlock_o(unlock_o),
   .hazard_o(hazard_o), .horn_o(horn_o), .start_en_o(start_en_o)
);
